// file: logic/crc_calc_unit.sv
// checksum engine: 16/32-bit remainder over byte, half-word and word writes
//
// Summary of operation
// - sixteen-bit mode with polynomial 0x8005
// - sixteen-bit ccitt mode with polynomial 0x1021
// - thirty-two-bit mode with polynomial 0x04C11DB7
// - complement, byte and bit reversal, data and result
// - accept byte, half-word or word writes
// - software loads any seed into remainder
// - one byte per cycle, word in four
// - consecutive dma writes checksum a block
// - result width follows selected polynomial
`timescale 1ns/1ps
module crc_calc_unit
	import crc_calc_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire crc_mode_e   mode,
	input  wire logic        data_cmpl,
	input  wire logic        data_byte_rev,
	input  wire logic        data_bit_rev,
	input  wire logic        sum_cmpl,
	input  wire logic        sum_byte_rev,
	input  wire logic        sum_bit_rev,
	input  wire logic        seed_load,
	input  wire logic [31:0] seed_value,
	input  wire logic        wr_valid,
	input  wire data_size_e  wr_size,
	input  wire logic [31:0] wr_data,
	output logic             wr_ready,
	output logic             busy,
	output logic [31:0]      sum_out
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [31:0] rem_q;
	logic [31:0] pend_q;
	logic [2:0]  cnt_q;
	logic [31:0] sum_q;
	logic        accept;
	logic [2:0]  nbytes;
	logic [7:0]  lane_cmp [4];
	logic [7:0]  lane_out [4];
	logic [31:0] dproc;
	logic [31:0] daligned;
	logic        wide;
	logic [31:0] wmask;
	logic [31:0] rev32;
	logic [15:0] rev16;
	logic [31:0] res;

	crc_step_if step_c ();

	crc_byte_step u_step (
		.s (step_c.step)
	);

	// ----------------------------------------------------------------
	// write acceptance
	// ----------------------------------------------------------------
	// a seed load in the same cycle wins, so the write is held off, not lost
	assign wr_ready = (cnt_q == 3'h0) && !seed_load;
	assign accept   = wr_valid && wr_ready;
	assign busy     = (cnt_q != 3'h0);

	// ----------------------------------------------------------------
	// input shaping
	// ----------------------------------------------------------------
	always_comb begin
		case (wr_size)
			SIZE_BYTE: nbytes = BYTES_BYTE;
			SIZE_HALF: nbytes = BYTES_HALF;
			SIZE_WORD: nbytes = BYTES_WORD;
			default:   nbytes = BYTES_WORD;
		endcase
	end

	// ----------------------------------------------------------------
	// one lane per written byte: complement, byte reversal, bit reversal
	// ----------------------------------------------------------------
	// lanes above the written size stay zero, so a short write never folds stale bits
	for (genvar g = 0; g < 4; g++) begin : g_lane
		logic       lane_on;
		logic [1:0] src;
		logic [7:0] pick;
		logic [7:0] flip;

		assign lane_on     = (g < int'(nbytes));
		assign lane_cmp[g] = lane_on ? (wr_data[8*g +: 8] ^ {8{data_cmpl}}) : 8'h00;
		assign src         = data_byte_rev ? 2'(int'(nbytes) - 1 - g) : 2'(g);
		assign pick        = lane_cmp[src];

		for (genvar b = 0; b < 8; b++) begin : g_bit
			assign flip[b] = pick[7 - b];
		end

		assign lane_out[g] = !lane_on ? 8'h00 : (data_bit_rev ? flip : pick);
	end

	assign dproc    = {lane_out[3], lane_out[2], lane_out[1], lane_out[0]};
	// most significant written byte is folded first
	assign daligned = dproc << (8 * (4 - int'(nbytes)));

	// ----------------------------------------------------------------
	// byte feed: one byte leaves the pending word per cycle
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pend_q <= 32'h0000_0000;
			cnt_q  <= 3'h0;
		end else if (seed_load) begin
			pend_q <= 32'h0000_0000;
			cnt_q  <= 3'h0;
		end else if (accept) begin
			pend_q <= daligned;
			cnt_q  <= nbytes;
		end else if (cnt_q != 3'h0) begin
			pend_q <= {pend_q[23:0], 8'h00};
			cnt_q  <= cnt_q - 3'h1;
		end
	end

	assign step_c.rem  = rem_q;
	assign step_c.din  = pend_q[31:24];
	assign step_c.mode = mode;

	// ----------------------------------------------------------------
	// running remainder
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rem_q <= REM_RESET;
		end else if (seed_load) begin
			rem_q <= seed_value;
		end else if (cnt_q != 3'h0) begin
			rem_q <= step_c.nxt;
		end
	end

	// ----------------------------------------------------------------
	// result shaping, never written back to the remainder
	// ----------------------------------------------------------------
	// mode 11 folds with the 32-bit polynomial, so the width follows bit 1 alone
	assign wide  = mode[1];
	assign wmask = wide ? 32'hffff_ffff : 32'h0000_ffff;

	// bit reversal spans the whole result width, not each byte
	for (genvar b = 0; b < 32; b++) begin : g_rev32
		assign rev32[b] = rem_q[31 - b];
	end

	for (genvar b = 0; b < 16; b++) begin : g_rev16
		assign rev16[b] = rem_q[15 - b];
	end

	always_comb begin
		res = rem_q & wmask;
		if (sum_bit_rev) begin
			res = wide ? rev32 : {16'h0000, rev16};
		end
		if (sum_byte_rev) begin
			if (wide) begin
				res = {res[7:0], res[15:8], res[23:16], res[31:24]};
			end else begin
				res = {16'h0000, res[7:0], res[15:8]};
			end
		end
		if (sum_cmpl) res = res ^ wmask;
	end

	// registered copy keeps the output glitch free; one cycle behind rem_q
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sum_q <= SUM_RESET;
		end else begin
			sum_q <= res;
		end
	end

	assign sum_out = sum_q;

endmodule : crc_calc_unit

// file: logic/crc_calc_pkg.sv
// constants and types shared by the checksum engine
package crc_calc_pkg;

	// ----------------------------------------------------------------
	// generator polynomials
	// ----------------------------------------------------------------
	localparam logic [15:0] POLY_CRC16  = 16'h8005;
	localparam logic [15:0] POLY_CCITT  = 16'h1021;
	localparam logic [31:0] POLY_CRC32  = 32'h04C1_1DB7;

	// ----------------------------------------------------------------
	// reset values and counts
	// ----------------------------------------------------------------
	localparam logic [31:0] REM_RESET      = 32'h0000_0000;
	localparam logic [31:0] SUM_RESET      = 32'h0000_0000;
	localparam int          BITS_PER_STEP  = 8;
	localparam int          CYCLES_PER_BYTE = 1;
	localparam logic [2:0]  BYTES_BYTE     = 3'h1;
	localparam logic [2:0]  BYTES_HALF     = 3'h2;
	localparam logic [2:0]  BYTES_WORD     = 3'h4;

	// ----------------------------------------------------------------
	// modes and sizes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_CRC16 = 2'b00,
		MODE_CCITT = 2'b01,
		MODE_CRC32 = 2'b10
	} crc_mode_e;

	typedef enum logic [1:0] {
		SIZE_BYTE = 2'b00,
		SIZE_HALF = 2'b01,
		SIZE_WORD = 2'b10
	} data_size_e;

endpackage : crc_calc_pkg

// file: logic/crc_step_if.sv
// carrier between the engine and its one-byte fold stage
`timescale 1ns/1ps
interface crc_step_if;
	import crc_calc_pkg::*;
	logic [31:0] rem;
	logic [7:0]  din;
	crc_mode_e   mode;
	logic [31:0] nxt;

	modport engine (output rem, output din, output mode, input nxt);
	modport step   (input rem, input din, input mode, output nxt);
endinterface : crc_step_if

// file: logic/crc_byte_step.sv
// one-byte fold of the running remainder, all three polynomials
`timescale 1ns/1ps
module crc_byte_step
	import crc_calc_pkg::*;
(
	crc_step_if.step s
);

	// ----------------------------------------------------------------
	// msb-first shift over eight bits
	// ----------------------------------------------------------------
	logic [31:0] r32;
	logic [15:0] r16;
	logic [15:0] poly16;

	always_comb begin
		poly16 = (s.mode == MODE_CCITT) ? POLY_CCITT : POLY_CRC16;
		r32    = s.rem ^ {s.din, 24'h00_0000};
		r16    = s.rem[15:0] ^ {s.din, 8'h00};
		for (int i = 0; i < BITS_PER_STEP; i++) begin
			r32 = r32[31] ? ({r32[30:0], 1'b0} ^ POLY_CRC32) : {r32[30:0], 1'b0};
			r16 = r16[15] ? ({r16[14:0], 1'b0} ^ poly16) : {r16[14:0], 1'b0};
		end
		case (s.mode)
			MODE_CRC16,
			MODE_CCITT: s.nxt = {16'h0000, r16};
			MODE_CRC32: s.nxt = r32;
			default:    s.nxt = r32;
		endcase
	end

endmodule : crc_byte_step

// file: verif/crc_dma_model.sv
// write-side bus master model feeding the checksum engine
`timescale 1ns/1ps
module crc_dma_model
	import crc_calc_pkg::*;
(
	input  wire logic   ref_clk,
	input  wire logic   wr_ready,
	output logic        wr_valid,
	output data_size_e  wr_size,
	output logic [31:0] wr_data
);
	// ----
	// write driver
	// ----
	initial begin
		wr_valid = 1'b0;
		wr_size = SIZE_BYTE;
		wr_data = 32'h0000_0000;
	end
	// consecutive writes, request held until taken
	task send(data_size_e s, logic [31:0] d);
		@(negedge ref_clk);
		wr_valid = 1'b1;
		wr_size = s;
		wr_data = d;
		do @(posedge ref_clk); while (wr_ready !== 1'b1);
	endtask : send
	// a released bus must not keep showing the last word
	task rel();
		@(negedge ref_clk);
		wr_valid = 1'b0;
		wr_data = ~wr_data;
	endtask : rel
endmodule : crc_dma_model

// file: verif/crc_calc_sva.sv
// port checker for the checksum engine
`timescale 1ns/1ps
module crc_calc_sva
	import crc_calc_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire crc_mode_e   mode,
	input wire logic        sum_cmpl,
	input wire logic        sum_byte_rev,
	input wire logic        sum_bit_rev,
	input wire logic        seed_load,
	input wire logic [31:0] seed_value,
	input wire logic        wr_valid,
	input wire data_size_e  wr_size,
	input wire logic        wr_ready,
	input wire logic        busy,
	input wire logic [31:0] sum_out
);
	// ----
	// relations
	// ----
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire tk = wr_valid && wr_ready;
	wire raw = !sum_cmpl && !sum_byte_rev && !sum_bit_rev;
	AST_BUSY_HOLD: assert property (busy |-> !wr_ready)
		else $error("write accepted while busy");
	AST_SEED_HOLD: assert property (seed_load |-> !wr_ready)
		else $error("write accepted during seed load");
	AST_IDLE_RDY: assert property (!busy && !seed_load |-> wr_ready)
		else $error("idle engine refuses write");
	AST_BYTE_LAT: assert property (tk && wr_size == SIZE_BYTE |=> busy ##1 !busy)
		else $error("byte fold not one cycle");
	AST_HALF_LAT: assert property (tk && wr_size == SIZE_HALF |=> busy[*2] ##1 !busy)
		else $error("half-word fold not two cycles");
	AST_WORD_LAT: assert property (tk && wr_size[1] |=> busy[*4] ##1 !busy)
		else $error("word fold not four cycles");
	AST_SEED_OUT: assert property (seed_load && raw && mode == MODE_CRC32 |-> ##2 sum_out == $past(seed_value, 2))
		else $error("seed not shown on result");
	AST_W16: assert property (!mode[1] && $stable(mode) |-> sum_out[31:16] == 16'h0000)
		else $error("16-bit result has upper bits set");
	cover property (tk && wr_size == SIZE_WORD);
	cover property (tk && wr_size == SIZE_BYTE);
	cover property (seed_load ##1 tk);
endmodule : crc_calc_sva

// file: verif/crc_calc_unit_tb.sv
// self-checking bench for the checksum engine
`timescale 1ns/1ps
module crc_calc_unit_tb;
	import crc_calc_pkg::*;
	logic ref_clk, rst, seed_load, wr_valid, wr_ready, busy;
	logic data_cmpl, data_byte_rev, data_bit_rev, sum_cmpl, sum_byte_rev, sum_bit_rev;
	crc_mode_e   mode;
	data_size_e  wr_size;
	logic [31:0] seed_value, wr_data, sum_out, st, r, e, d;
	int          bad_count = 0, tests_run = 0, cyc = 0, w, n;
	crc_calc_unit uut (
		.ref_clk       (ref_clk),
		.rst           (rst),
		.mode          (mode),
		.data_cmpl     (data_cmpl),
		.data_byte_rev (data_byte_rev),
		.data_bit_rev  (data_bit_rev),
		.sum_cmpl      (sum_cmpl),
		.sum_byte_rev  (sum_byte_rev),
		.sum_bit_rev   (sum_bit_rev),
		.seed_load     (seed_load),
		.seed_value    (seed_value),
		.wr_valid      (wr_valid),
		.wr_size       (wr_size),
		.wr_data       (wr_data),
		.wr_ready      (wr_ready),
		.busy          (busy),
		.sum_out       (sum_out)
	);
	crc_dma_model dma (
		.ref_clk  (ref_clk),
		.wr_ready (wr_ready),
		.wr_valid (wr_valid),
		.wr_size  (wr_size),
		.wr_data  (wr_data)
	);
	// ----
	// reference and reporting
	// ----
	function logic [31:0] rnd();
		st = st ^ (st << 13);
		st = st ^ (st >> 17);
		st = st ^ (st << 5);
		return st;
	endfunction : rnd
	// complement commutes with both reversals, so one helper serves data and result
	function automatic logic [31:0] shp(logic [31:0] x, int k, logic c, logic by, logic bi);
		logic [31:0] y = 32'h0000_0000;
		if (c) x = ~x;
		for (int i = 0; i < 8 * k; i++) y[8 * (by ? k - 1 - i / 8 : i / 8) + (bi ? 7 - i % 8 : i % 8)] = x[i];
		return y;
	endfunction : shp
	function automatic logic [31:0] fold(logic [31:0] x, logic [7:0] b);
		logic [31:0] p = w == 32 ? POLY_CRC32 : {16'h0000, mode == MODE_CCITT ? POLY_CCITT : POLY_CRC16};
		for (int i = 7; i >= 0; i--) x = {x[30:0], 1'b0} ^ ((x[w - 1] ^ b[i]) ? p : 32'h0000_0000);
		return w == 32 ? x : {16'h0000, x[15:0]};
	endfunction : fold
	// result bit reversal spans the whole width: a byte swap plus a reversal per byte
	function automatic logic [31:0] res_shp(logic [31:0] x);
		return shp(x, w / 8, sum_cmpl, sum_byte_rev ^ sum_bit_rev, sum_bit_rev);
	endfunction : res_shp
	task chk(string nm, logic [31:0] ex, logic [31:0] got);
		tests_run++;
		if (got !== ex) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	task end_of_test();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	// ----
	// clock, watchdog, stimulus
	// ----
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			end_of_test();
		end
	end
	initial begin
		st = 32'h0001_3704;
		{rst, seed_load, seed_value, mode} = {2'b10, 32'h0000_0000, MODE_CRC16};
		{data_cmpl, data_byte_rev, data_bit_rev, sum_cmpl, sum_byte_rev, sum_bit_rev} = 6'h00;
		repeat (12) @(posedge ref_clk);
		@(negedge ref_clk) rst = 1'b0;
		chk("reset sum_out", 32'h0000_0000, sum_out);
		chk("reset busy", 32'h0000_0000, {31'h0000_0000, busy});
		chk("reset wr_ready", 32'h0000_0001, {31'h0000_0000, wr_ready});
		for (int t = 0; t < 64; t++) begin
			@(negedge ref_clk);
			e = rnd();
			{data_cmpl, data_byte_rev, data_bit_rev, sum_cmpl, sum_byte_rev, sum_bit_rev} = t < 4 ? 6'h00 : e[5:0];
			mode = crc_mode_e'(t % 4);
			seed_value = t == 0 ? 32'hFFFF_FFFF : rnd();
			seed_load = 1'b1;
			w = mode inside {MODE_CRC16, MODE_CCITT} ? 16 : 32;
			r = w == 32 ? seed_value : {16'h0000, seed_value[15:0]};
			@(negedge ref_clk) seed_load = 1'b0;
			repeat (2) @(negedge ref_clk);
			chk("seed sum_out", res_shp(r), sum_out);
			for (int k = 0; k < 4; k++) begin
				e = t < 2 ? {32{t == 1}} : rnd();
				n = e[1:0] == 2'b00 ? 1 : e[1:0] == 2'b01 ? 2 : 4;
				d = shp(e, n, data_cmpl, data_byte_rev, data_bit_rev);
				for (int j = n - 1; j >= 0; j--) r = fold(r, d[8 * j +: 8]);
				dma.send(data_size_e'(e[1:0]), e);
			end
			dma.rel();
			for (int i = 0; i < 8 && busy !== 1'b0; i++) @(negedge ref_clk);
			repeat (2) begin
				@(negedge ref_clk);
				chk("sum_out", res_shp(r), sum_out);
			end
		end
		end_of_test();
	end
endmodule : crc_calc_unit_tb
bind crc_calc_unit crc_calc_sva sva (
	.ref_clk      (ref_clk),
	.rst          (rst),
	.mode         (mode),
	.sum_cmpl     (sum_cmpl),
	.sum_byte_rev (sum_byte_rev),
	.sum_bit_rev  (sum_bit_rev),
	.seed_load    (seed_load),
	.seed_value   (seed_value),
	.wr_valid     (wr_valid),
	.wr_size      (wr_size),
	.wr_ready     (wr_ready),
	.busy         (busy),
	.sum_out      (sum_out)
);
